/* File: include/pio_pkg.sv */
package pio_pkg;

	// Register indices as printed; not all are multiples of four.
	localparam logic [11:0] IDX_B_DIR  = 12'h2C6;
	localparam logic [11:0] IDX_B_PIN  = 12'h2C8;
	localparam logic [11:0] IDX_B_LAT  = 12'h2CB;
	localparam logic [11:0] IDX_C_DIR  = 12'h2CC;
	localparam logic [11:0] IDX_C_PIN  = 12'h2CE;
	localparam logic [11:0] IDX_C_LAT  = 12'h2D0;
	localparam logic [11:0] IDX_D_DIR  = 12'h2D2;
	localparam logic [11:0] IDX_D_PIN  = 12'h2D4;
	localparam logic [11:0] IDX_D_LAT  = 12'h2D6;
	localparam logic [11:0] IDX_F_DIR  = 12'h2DE;
	localparam logic [11:0] IDX_F_PIN  = 12'h2E0;
	localparam logic [11:0] IDX_F_LAT  = 12'h2E2;

	// Implemented-bit masks, larger variant and smaller variant.
	localparam logic [15:0] MASK_B_BIG   = 16'h03FF;
	localparam logic [15:0] MASK_B_SMALL = 16'h00FF;
	localparam logic [15:0] MASK_C       = 16'hE000;
	localparam logic [15:0] MASK_D_BIG   = 16'h0300;
	localparam logic [15:0] MASK_D_SMALL = 16'h0001;
	localparam logic [15:0] MASK_F_BIG   = 16'h007C;
	localparam logic [15:0] MASK_F_SMALL = 16'h0000;

	// Latch and sampled level reset value.
	localparam logic [15:0] RST_ZERO = 16'h0000;

	// Bus response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: rtl/pio_ports.sv */
`timescale 1ns/1ps

// Contract
// - Unimplemented register bits read zero and ignore writes.
// - Larger variant group B has pins 0 to 9; direction resets to 0x03FF.
// - Smaller variant group B has pins 0 to 7; direction resets to 0x00FF.
// - Group C has pins 13 to 15 only; direction resets to 0xE000.
// - Smaller variant group D has pin 0 only; direction resets to 0x0001.
// - Larger variant group F has pins 2 to 6; direction resets to 0x007C.
// - The smaller variant has no group F registers at all.
// - Level and latch registers reset to zero so outputs stay low.
// - Direction one makes the pin an input, driver off; zero an output.
// - Reading a level register gives sampled pins; writing it sets the latch.
// - Reading a latch register returns the latch, not the pins.
module pio_ports
	import pio_pkg::*;
#(
	parameter bit BIG_VARIANT = 1'b1
)
(
	// Clock and reset.
	input  wire logic        sys_clk,
	input  wire logic        srst,
	// AXI4-Lite write address and data.
	input  wire logic [13:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read.
	input  wire logic [13:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Pins, one word per group: B, C, D, F.
	input  wire logic [63:0] pin_in,
	output logic      [63:0] pin_out,
	output logic      [63:0] pin_oe
);

	localparam logic [63:0] MASK_ALL = {
		(BIG_VARIANT ? MASK_F_BIG : MASK_F_SMALL),
		(BIG_VARIANT ? MASK_D_BIG : MASK_D_SMALL),
		MASK_C,
		(BIG_VARIANT ? MASK_B_BIG : MASK_B_SMALL)};

	logic [63:0] dir_r, dir_nxt, lat_r, lat_nxt;
	logic [63:0] sync1_r, sync2_r, pout_r, pout_nxt, poe_r, poe_nxt;
	logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic [11:0] aw_idx_r, aw_idx_nxt;
	logic [15:0] wd_r, wd_nxt;
	logic [1:0]  wstrb_r, wstrb_nxt;
	logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic        awready_r, wready_r, arready_r;
	logic        awready_nxt, wready_nxt, arready_nxt;

	// Map a word index to a group (0..3) and kind (0 dir,1 pin,2 lat).
	function automatic logic [4:0] decode(input logic [11:0] idx);
		logic [4:0] d;
		d = 5'h00;
		case (idx)
			IDX_B_DIR: d = {1'b1, 2'd0, 2'd0};
			IDX_B_PIN: d = {1'b1, 2'd0, 2'd1};
			IDX_B_LAT: d = {1'b1, 2'd0, 2'd2};
			IDX_C_DIR: d = {1'b1, 2'd1, 2'd0};
			IDX_C_PIN: d = {1'b1, 2'd1, 2'd1};
			IDX_C_LAT: d = {1'b1, 2'd1, 2'd2};
			IDX_D_DIR: d = {1'b1, 2'd2, 2'd0};
			IDX_D_PIN: d = {1'b1, 2'd2, 2'd1};
			IDX_D_LAT: d = {1'b1, 2'd2, 2'd2};
			// The smaller variant leaves group F unmapped.
			IDX_F_DIR: d = {BIG_VARIANT, 2'd3, 2'd0};
			IDX_F_PIN: d = {BIG_VARIANT, 2'd3, 2'd1};
			IDX_F_LAT: d = {BIG_VARIANT, 2'd3, 2'd2};
			default:   d = 5'h00;
		endcase
		return d;
	endfunction

	// Write path: address and data taken in any order, then one response.
	always_comb
	begin
		logic [4:0]  wd;
		logic [15:0] bmask, wmask;
		wd = decode(aw_idx_r);
		bmask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
		wmask = bmask & MASK_ALL[wd[3:2]*16 +: 16];
		aw_got_nxt = aw_got_r;
		w_got_nxt = w_got_r;
		aw_idx_nxt = aw_idx_r;
		wd_nxt = wd_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		dir_nxt = dir_r;
		lat_nxt = lat_r;
		if (s_axi_awvalid && awready_r)
		begin
			aw_got_nxt = 1'b1;
			aw_idx_nxt = s_axi_awaddr[13:2];
		end
		if (s_axi_wvalid && wready_r)
		begin
			w_got_nxt = 1'b1;
			wd_nxt = s_axi_wdata[15:0];
			wstrb_nxt = s_axi_wstrb[1:0];
		end
		if (aw_got_r && w_got_r && !bvalid_r)
		begin
			aw_got_nxt = 1'b0;
			w_got_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = wd[4] ? RESP_OKAY : RESP_SLVERR;
			if (wd[4] && wd[1:0] == 2'd0)
				dir_nxt[wd[3:2]*16 +: 16] = (dir_r[wd[3:2]*16 +: 16] & ~wmask)
					| (wd_r & wmask);
			// Level-register writes land in the latch.
			else if (wd[4])
				lat_nxt[wd[3:2]*16 +: 16] = (lat_r[wd[3:2]*16 +: 16] & ~wmask)
					| (wd_r & wmask);
		end
		if (bvalid_r && s_axi_bready)
			bvalid_nxt = 1'b0;
		awready_nxt = !aw_got_nxt && !bvalid_nxt;
		wready_nxt = !w_got_nxt && !bvalid_nxt;
	end

	// Read path: one cycle from address acceptance to valid data.
	always_comb
	begin
		logic [4:0]  rd;
		logic [15:0] v;
		rd = decode(s_axi_araddr[13:2]);
		v = 16'h0000;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		case (rd[1:0])
			2'd0:    v = dir_r[rd[3:2]*16 +: 16];
			2'd1:    v = sync2_r[rd[3:2]*16 +: 16];
			2'd2:    v = lat_r[rd[3:2]*16 +: 16];
			default: v = 16'h0000;
		endcase
		if (s_axi_arvalid && arready_r)
		begin
			rvalid_nxt = 1'b1;
			rdata_nxt = {16'h0000, v & MASK_ALL[rd[3:2]*16 +: 16]};
			if (!rd[4])
				rdata_nxt = 32'h0000_0000;
			rresp_nxt = rd[4] ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_r && s_axi_rready)
			rvalid_nxt = 1'b0;
		arready_nxt = !rvalid_nxt;
	end

	// Pad drive: direction one turns the driver off.
	always_comb
	begin
		poe_nxt = ~dir_nxt & MASK_ALL;
		pout_nxt = lat_nxt & MASK_ALL;
	end

	// Registers. Direction resets to the implemented mask, so all pins
	// come up as inputs with the drivers off.
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			dir_r <= MASK_ALL;
			lat_r <= {4{RST_ZERO}};
			sync1_r <= {4{RST_ZERO}};
			sync2_r <= {4{RST_ZERO}};
			pout_r <= {4{RST_ZERO}};
			poe_r <= {4{RST_ZERO}};
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_idx_r <= 12'h000;
			wd_r <= 16'h0000;
			wstrb_r <= 2'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h0000_0000;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			arready_r <= 1'b0;
		end
		else
		begin
			dir_r <= dir_nxt;
			lat_r <= lat_nxt;
			// Two stages; the pin word seen by reads lags the pins by two
			// clocks, which is why software needs the spare cycle.
			sync1_r <= pin_in;
			sync2_r <= sync1_r & MASK_ALL;
			pout_r <= pout_nxt;
			poe_r <= poe_nxt;
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			aw_idx_r <= aw_idx_nxt;
			wd_r <= wd_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			arready_r <= arready_nxt;
		end
	end

	// Output ports come straight from flip-flops.
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
	assign pin_out = pout_r;
	assign pin_oe = poe_r;

	// Checks.
	a_unimpl_quiet: assert property (@(posedge sys_clk) disable iff (srst)
		(pin_oe & ~MASK_ALL) == 64'h0 && (pin_out & ~MASK_ALL) == 64'h0)
		else $error("unimplemented pin driven");
	a_reset_dir: assert property (@(posedge sys_clk)
		$past(srst) |-> dir_r == MASK_ALL && pin_oe == 64'h0)
		else $error("direction reset value wrong");
	a_reset_lat: assert property (@(posedge sys_clk)
		$past(srst) |-> lat_r == 64'h0 && pin_out == 64'h0)
		else $error("latch not cleared by reset");
	a_oe_follows: assert property (@(posedge sys_clk) disable iff (srst)
		$past(!srst) |-> pin_oe == ($past(~dir_nxt) & MASK_ALL))
		else $error("driver enable does not follow direction");
	a_out_follows: assert property (@(posedge sys_clk) disable iff (srst)
		##1 pin_out == ($past(lat_r, 1) & MASK_ALL) || $changed(lat_r))
		else $error("pin output not latch");
	a_pin_sync: assert property (@(posedge sys_clk) disable iff (srst)
		##2 sync2_r == ($past(pin_in, 2) & MASK_ALL))
		else $error("sampled level wrong");
	a_read_rdhi: assert property (@(posedge sys_clk) disable iff (srst)
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
		else $error("upper read bits nonzero");
	a_f_absent: assert property (@(posedge sys_clk) disable iff (srst)
		!BIG_VARIANT |-> pin_oe[63:48] == 16'h0 && dir_r[63:48] == 16'h0)
		else $error("group F present on smaller variant");
	a_pinwr_lat: assert property (@(posedge sys_clk) disable iff (srst)
		(aw_got_r && w_got_r && !bvalid_r && decode(aw_idx_r) ==
		{1'b1, 2'd0, 2'd1} && wstrb_r == 2'h3) |=> lat_r[15:0] ==
		($past(wd_r) & MASK_ALL[15:0]))
		else $error("level write did not reach latch");
	a_resp_hold: assert property (@(posedge sys_clk) disable iff (srst)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");

	// Write answer must stand until taken, or software loses the status.
	a_wresp_hold: assert property (@(posedge sys_clk) disable iff (srst)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	// Unmapped reads must not leak stale data onto the bus.
	a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (srst)
		s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("unmapped read returned data");
	// An input pin must never have its driver on.
	a_input_quiet: assert property (@(posedge sys_clk) disable iff (srst)
		(pin_oe & dir_r) == 64'h0)
		else $error("driver on for an input pin");
	// Address and data are refused while a write answer is pending.
	a_ready_low: assert property (@(posedge sys_clk) disable iff (srst)
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while answer pending");

	// Main scenarios worth seeing at least once.
	c_write: cover property (@(posedge sys_clk) s_axi_bvalid && s_axi_bready);
	c_read: cover property (@(posedge sys_clk) s_axi_rvalid && s_axi_rready);
	c_drive: cover property (@(posedge sys_clk) pin_oe[0]);
	c_err: cover property (@(posedge sys_clk) s_axi_rvalid &&
		s_axi_rresp == RESP_SLVERR);
	c_werr: cover property (@(posedge sys_clk) s_axi_bvalid &&
		s_axi_bresp == RESP_SLVERR);

endmodule

/* File: bench/pio_pins.sv */
`timescale 1ns/1ps

module pio_pins
(
	// Design side.
	input  wire logic [63:0] pin_out,
	input  wire logic [63:0] pin_oe,
	// Board side.
	input  wire logic [63:0] board,
	output logic      [63:0] pin_in
);
	// A driven pin shows its latch; an undriven one shows the board level.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & board);
endmodule

/* File: bench/pio_ports_tb.sv */
`timescale 1ns/1ps

module pio_ports_tb
	import pio_pkg::*;
;
	logic        sys_clk, srst, awvalid, wvalid, bready, arvalid, rready;
	logic [13:0] awaddr, araddr;
	logic [31:0] wdata, seed;
	logic [63:0] board;
	logic [1:0]  awr, wr_r, bv, arr, rv;
	logic [1:0]  bresp [2], rresp [2];
	logic [31:0] rdata [2];
	logic [63:0] pout [2], poe [2], pin [2];
	logic [15:0] msk [2][4], dir [2][4], lat [2][4];
	logic [11:0] ix [4][3];
	logic [35:0] q [$];
	logic [35:0] e;
	int          failures, compares;

	// Both variants see the same requests; the bench paces on the first.
	for (genvar v = 0; v < 2; v++)
	begin : g_var
		pio_ports #(.BIG_VARIANT(v == 0)) pio_ports_inst (
			.sys_clk(sys_clk), .srst(srst), .s_axi_awaddr(awaddr),
			.s_axi_awvalid(awvalid), .s_axi_awready(awr[v]),
			.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
			.s_axi_wready(wr_r[v]), .s_axi_bresp(bresp[v]),
			.s_axi_bvalid(bv[v]), .s_axi_bready(bready),
			.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
			.s_axi_arready(arr[v]), .s_axi_rdata(rdata[v]),
			.s_axi_rresp(rresp[v]), .s_axi_rvalid(rv[v]),
			.s_axi_rready(rready), .pin_in(pin[v]), .pin_out(pout[v]),
			.pin_oe(poe[v]));
		pio_pins pio_pins_inst (.pin_out(pout[v]), .pin_oe(poe[v]),
			.board(board), .pin_in(pin[v]));
	end

	// Free-running system clock.
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic check(input string nm, input logic [63:0] seen, exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Expected response and data; pads of outputs loop back their latch.
	function automatic logic [17:0] expv(int v, int g, int k);
		logic [15:0] pad;
		pad = (board[16*g+:16] & dir[v][g]) | (lat[v][g] & ~dir[v][g]);
		if (v == 1 && g == 3)
			return {RESP_SLVERR, 16'h0000};
		return {RESP_OKAY, k == 0 ? dir[v][g] :
			k == 1 ? pad & msk[v][g] : lat[v][g]};
	endfunction

	// Read: the note goes on the queue, the monitor checks the answer.
	task automatic rd(input logic [13:0] a, input logic [35:0] x);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		q.push_back(x);
		do @(posedge sys_clk); while (!arr[0]);
		arvalid <= 1'b0;
		do @(posedge sys_clk); while (!rv[0]);
		rready <= 1'b0;
		@(posedge sys_clk);
	endtask

	// Write: address and data are released independently when taken.
	task automatic wr(input int g, k, input logic [31:0] d);
		logic a, w;
		awaddr <= {ix[g][k], 2'b00};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		a = 1'b1;
		w = 1'b1;
		do
		begin
			@(posedge sys_clk);
			a = a & ~awr[0];
			w = w & ~wr_r[0];
			awvalid <= a;
			wvalid <= w;
		end while (a | w);
		do @(posedge sys_clk); while (!bv[0]);
		bready <= 1'b0;
		check("bresp0", bresp[0], RESP_OKAY);
		check("bresp1", bresp[1], g == 3 ? RESP_SLVERR : RESP_OKAY);
		for (int v = 0; v < 2; v++)
			if (k == 0)
				dir[v][g] = d[15:0] & msk[v][g];
			else
				lat[v][g] = d[15:0] & msk[v][g];
		for (int v = 0; v < 2; v++)
		begin
			check("pin_out", pout[v][16*g+:16], lat[v][g]);
			check("pin_oe", poe[v][16*g+:16], ~dir[v][g] & msk[v][g]);
		end
		@(posedge sys_clk);
	endtask

	task automatic tally_and_finish();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Read monitor: every answer is matched against the oldest note.
	always @(posedge sys_clk)
		if (rv[0] && rready)
		begin
			e = q.pop_front();
			check("read0", {rresp[0], rdata[0]},
				{e[17:16], 16'h0000, e[15:0]});
			check("read1", {rv[1], rresp[1], rdata[1]},
				{1'b1, e[35:34], 16'h0000, e[33:18]});
		end

	// Watchdog, well beyond the few hundred cycles the run needs.
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		tally_and_finish();
	end

	initial
	begin
		{srst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
		{awaddr, araddr, wdata, board} = '0;
		seed = 32'hE218DD15;
		ix = '{'{IDX_B_DIR, IDX_B_PIN, IDX_B_LAT},
			'{IDX_C_DIR, IDX_C_PIN, IDX_C_LAT},
			'{IDX_D_DIR, IDX_D_PIN, IDX_D_LAT},
			'{IDX_F_DIR, IDX_F_PIN, IDX_F_LAT}};
		msk[0] = '{MASK_B_BIG, MASK_C, MASK_D_BIG, MASK_F_BIG};
		msk[1] = '{MASK_B_SMALL, MASK_C, MASK_D_SMALL, MASK_F_SMALL};
		dir = msk;
		lat = '{default: RST_ZERO};
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		// Reset values of every register, then an unmapped index.
		for (int g = 0; g < 4; g++)
			for (int k = 0; k < 3; k++)
				rd({ix[g][k], 2'b00}, {expv(1, g, k), expv(0, g, k)});
		rd(14'h0000, {RESP_SLVERR, 16'h0000, RESP_SLVERR, 16'h0000});
		// Random directions and latches, written by both register kinds.
		for (int p = 0; p < 4; p++)
		begin
			board <= {xs(), xs()};
			for (int g = 0; g < 4; g++)
			begin
				wr(g, 0, xs());
				wr(g, p[0] ? 1 : 2, xs());
			end
			repeat (3) @(posedge sys_clk);
			for (int g = 0; g < 4; g++)
				for (int k = 0; k < 3; k++)
					rd({ix[g][k], 2'b00}, {expv(1, g, k), expv(0, g, k)});
		end
		tally_and_finish();
	end
endmodule
